// >>> hdl/btcx_defs.vh
// Constants for the bit-test and call execution unit.
// Assumes inclusion by bare name from the design and verification files.
`ifndef BTCX_DEFS_VH
`define BTCX_DEFS_VH
// Register byte offsets on the APB bus
`define BTCX_OFF_INSTR 8'h00
`define BTCX_OFF_ACC 8'h04
`define BTCX_OFF_PC 8'h08
`define BTCX_OFF_PC_HIGH 8'h0C
`define BTCX_OFF_TABLE_HIGH 8'h10
`define BTCX_OFF_STATUS 8'h14
`define BTCX_OFF_STACK_TOP 8'h18
`define BTCX_OFF_FILE_ADDR 8'h1C
`define BTCX_OFF_FILE_DATA 8'h20
`define BTCX_OFF_CYCLES 8'h24
// Instruction register field positions
`define BTCX_OP_MSB 2
`define BTCX_OP_LSB 0
`define BTCX_BIT_MSB 6
`define BTCX_BIT_LSB 4
`define BTCX_FA_MSB 13
`define BTCX_FA_LSB 8
`define BTCX_IMM_MSB 23
`define BTCX_IMM_LSB 16
// Status register bit positions
`define BTCX_ST_ZERO 0
`define BTCX_ST_BUSY 1
`define BTCX_ST_SP_MSB 6
`define BTCX_ST_SP_LSB 4
// Operation codes
`define BTCX_OPC_AND_IMM 3'h0
`define BTCX_OPC_SET_BIT 3'h1
`define BTCX_OPC_SKIP_CLR 3'h2
`define BTCX_OPC_SKIP_SET 3'h3
`define BTCX_OPC_CALL_DIR 3'h4
`define BTCX_OPC_CALL_ACC 3'h5
// Reset values
`define BTCX_RST_ACC 8'h00
`define BTCX_RST_PC 10'h000
`define BTCX_RST_HIGH 2'h0
`define BTCX_RST_FILE_ADDR 6'h00
// Sizes
`define BTCX_FILE_DEPTH 64
`define BTCX_STACK_DEPTH 8
`endif

// >>> hdl/btcx_file_ram.v
// File register memory: 64 words of 8 bits, one write port.
// Assumes one clock; read data come out of a register one edge later.
`timescale 1ns/1ps
module btcx_file_ram
(
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_we,
  input wire [5:0] i_waddr,
  input wire [7:0] i_wdata,
  input wire [5:0] i_raddr,
  output wire [7:0] o_rdata
);

  // Storage array, not reset
  reg [7:0] mem_q [0:63];
  // Registered read data
  reg [7:0] rdata_q;

  // Write port
  always @(posedge i_core_clk)
  begin
    if (i_we)
    begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // Read port; a write to the word being read is passed through, so a
  // read-modify-write never leaves stale data for the next reader
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (i_we && (i_waddr == i_raddr))
    begin
      rdata_q <= i_wdata;
    end
    else
    begin
      rdata_q <= mem_q[i_raddr];
    end
  end

  assign o_rdata = rdata_q;

endmodule // btcx_file_ram

// >>> hdl/btcx_exec_unit.v
// Execution unit for AND-immediate, set-bit, bit-test skips and calls.
// Assumes an APB master on the same clock; one operation at a time.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "btcx_defs.vh"
module btcx_exec_unit
(
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  output wire [9:0] o_pc,
  output wire o_flush,
  output wire o_busy
);

  // One-hot execution states
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_READ = 4'h2;
  localparam [3:0] S_EXEC1 = 4'h4;
  localparam [3:0] S_EXEC2 = 4'h8;

  // One-hot mask for a bit index, shared by set and test
  function [7:0] bit_mask;
    input [2:0] idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  // Operations that need the addressed file register first
  function needs_file;
    input [2:0] op;
    begin
      needs_file = (op == `BTCX_OPC_SET_BIT) ||
                   (op == `BTCX_OPC_SKIP_CLR) ||
                   (op == `BTCX_OPC_SKIP_SET);
    end
  endfunction

  // Architectural state
  reg [7:0] acc_q; // Accumulator
  reg zero_q; // Zero flag
  reg [9:0] pc_q; // Program counter
  reg [1:0] pc_high_buf_q; // Program counter high buffer
  reg [1:0] table_high_q; // Table high pointer
  reg [2:0] sp_q; // Stack pointer, wraps at depth
  reg [9:0] stack_q [0:`BTCX_STACK_DEPTH-1]; // Return addresses
  reg [5:0] faddr_q; // Software file register window
  reg [15:0] cycles_q; // Retired instruction cycles

  // Latched operation
  reg [3:0] state_q;
  reg [2:0] op_q;
  reg [2:0] bit_q;
  reg [5:0] fa_q;
  reg [7:0] imm_q;
  reg flush_q; // Discard pulse to the fetch stage

  // APB answer registers
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;

  // File memory hookup
  wire [7:0] file_rdata;
  wire [5:0] file_raddr;
  reg file_we;
  reg [5:0] file_waddr;
  reg [7:0] file_wdata;

  wire busy = (state_q != S_IDLE);
  wire [9:0] pc_plus1 = pc_q + 10'h001;
  wire [7:0] sel_mask = bit_mask(bit_q);
  wire bit_is_set = |(file_rdata & sel_mask);
  wire and_res_zero = ((acc_q & imm_q) == 8'h00);

  // Bus is stalled while an operation runs; avoids two writers per cycle
  wire acc_phase = i_psel & i_penable & ~pready_q & ~busy;
  wire done_phase = i_psel & i_penable & pready_q;
  wire bus_wr = done_phase & i_pwrite;
  wire issue = bus_wr && (i_paddr == `BTCX_OFF_INSTR);

  // Skip decision taken in the first cycle
  wire skip_taken = ((op_q == `BTCX_OPC_SKIP_CLR) && !bit_is_set) ||
                    ((op_q == `BTCX_OPC_SKIP_SET) && bit_is_set);
  wire is_call = (op_q == `BTCX_OPC_CALL_DIR) ||
                 (op_q == `BTCX_OPC_CALL_ACC);
  wire push = (state_q == S_EXEC1) && is_call;

  // Memory reads the operand while busy, the window otherwise
  assign file_raddr = busy ? fa_q : faddr_q;

  btcx_file_ram u_file_ram
  (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_we(file_we),
    .i_waddr(file_waddr),
    .i_wdata(file_wdata),
    .i_raddr(file_raddr),
    .o_rdata(file_rdata)
  );

  // Memory write source: set-bit in flight, else software
  always @*
  begin
    file_we = 1'b0;
    file_waddr = faddr_q;
    file_wdata = i_pwdata[7:0];
    if ((state_q == S_EXEC1) && (op_q == `BTCX_OPC_SET_BIT))
    begin
      file_we = 1'b1;
      file_waddr = fa_q;
      file_wdata = file_rdata | sel_mask;
    end
    else if (bus_wr && (i_paddr == `BTCX_OFF_FILE_DATA))
    begin
      file_we = 1'b1;
    end
  end

  // Sequencer; operand fetch step is not an instruction cycle
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= S_IDLE;
      op_q <= 3'h0;
      bit_q <= 3'h0;
      fa_q <= 6'h00;
      imm_q <= 8'h00;
      flush_q <= 1'b0;
    end
    else
    begin
      flush_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (issue)
          begin
            op_q <= i_pwdata[`BTCX_OP_MSB:`BTCX_OP_LSB];
            bit_q <= i_pwdata[`BTCX_BIT_MSB:`BTCX_BIT_LSB];
            fa_q <= i_pwdata[`BTCX_FA_MSB:`BTCX_FA_LSB];
            imm_q <= i_pwdata[`BTCX_IMM_MSB:`BTCX_IMM_LSB];
            if (needs_file(i_pwdata[`BTCX_OP_MSB:`BTCX_OP_LSB]))
            begin
              state_q <= S_READ;
            end
            else
            begin
              state_q <= S_EXEC1;
            end
          end
        end
        S_READ:
        begin
          state_q <= S_EXEC1;
        end
        S_EXEC1:
        begin
          // Second cycle for calls and taken skips only
          if (is_call || skip_taken)
          begin
            state_q <= S_EXEC2;
          end
          else
          begin
            state_q <= S_IDLE;
          end
          // Fetched successor is dropped, a no-op runs instead
          if (skip_taken)
          begin
            flush_q <= 1'b1;
          end
        end
        S_EXEC2:
        begin
          state_q <= S_IDLE;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Accumulator and zero flag; AND-immediate writes both, software writes the accumulator only
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_q <= `BTCX_RST_ACC;
      zero_q <= 1'b0;
    end
    else if ((state_q == S_EXEC1) && (op_q == `BTCX_OPC_AND_IMM))
    begin
      acc_q <= acc_q & imm_q;
      zero_q <= and_res_zero;
    end
    else if (bus_wr && (i_paddr == `BTCX_OFF_ACC))
    begin
      acc_q <= i_pwdata[7:0];
    end
  end

  // Program counter: step, skip step, or call target
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pc_q <= `BTCX_RST_PC;
    end
    else if (state_q == S_EXEC1)
    begin
      if (op_q == `BTCX_OPC_CALL_DIR)
      begin
        pc_q <= {pc_high_buf_q, imm_q};
      end
      else if (op_q == `BTCX_OPC_CALL_ACC)
      begin
        pc_q <= {table_high_q, acc_q};
      end
      else
      begin
        pc_q <= pc_plus1;
      end
    end
    else if ((state_q == S_EXEC2) && !is_call)
    begin
      pc_q <= pc_plus1;
    end
    else if (bus_wr && (i_paddr == `BTCX_OFF_PC))
    begin
      pc_q <= i_pwdata[9:0];
    end
  end

  // Software-only registers
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pc_high_buf_q <= `BTCX_RST_HIGH;
      table_high_q <= `BTCX_RST_HIGH;
      faddr_q <= `BTCX_RST_FILE_ADDR;
    end
    else if (bus_wr)
    begin
      if (i_paddr == `BTCX_OFF_PC_HIGH)
      begin
        pc_high_buf_q <= i_pwdata[1:0];
      end
      if (i_paddr == `BTCX_OFF_TABLE_HIGH)
      begin
        table_high_q <= i_pwdata[1:0];
      end
      if (i_paddr == `BTCX_OFF_FILE_ADDR)
      begin
        faddr_q <= i_pwdata[5:0];
      end
    end
  end

  // Stack pointer; overflow simply wraps, no trap
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sp_q <= 3'h0;
    end
    else if (push)
    begin
      sp_q <= sp_q + 3'h1;
    end
  end

  // Stack entries, each loads when the pointer selects it, one above the top
  genvar gi;
  generate
    for (gi = 0; gi < `BTCX_STACK_DEPTH; gi = gi + 1)
    begin : g_stack
      // Slot number of this entry, cut to the pointer width
      localparam [31:0] SLOT_W = gi;
      localparam [2:0] SLOT = SLOT_W[2:0];
      always @(posedge i_core_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          stack_q[gi] <= 10'h000;
        end
        else if (push && (sp_q == SLOT))
        begin
          stack_q[gi] <= pc_plus1;
        end
      end
    end
  endgenerate

  // Instruction cycle counter, one count per executed cycle
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cycles_q <= 16'h0000;
    end
    else if ((state_q == S_EXEC1) || (state_q == S_EXEC2))
    begin
      cycles_q <= cycles_q + 16'h0001;
    end
  end

  // Read data for the addressed register
  reg [31:0] rd_mux;
  reg rd_hit;
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (i_paddr)
      `BTCX_OFF_INSTR: rd_mux = {8'h00, imm_q, 2'h0, fa_q, 1'b0, bit_q,
                                1'b0, op_q};
      `BTCX_OFF_ACC: rd_mux = {24'h000000, acc_q};
      `BTCX_OFF_PC: rd_mux = {22'h000000, pc_q};
      `BTCX_OFF_PC_HIGH: rd_mux = {30'h00000000, pc_high_buf_q};
      `BTCX_OFF_TABLE_HIGH: rd_mux = {30'h00000000, table_high_q};
      `BTCX_OFF_STATUS: rd_mux = {25'h0000000, sp_q, 2'h0, busy, zero_q};
      `BTCX_OFF_STACK_TOP: rd_mux = {22'h000000, stack_q[sp_q - 3'h1]};
      `BTCX_OFF_FILE_ADDR: rd_mux = {26'h0000000, faddr_q};
      `BTCX_OFF_FILE_DATA: rd_mux = {24'h000000, file_rdata};
      `BTCX_OFF_CYCLES: rd_mux = {16'h0000, cycles_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // APB answer: ready one cycle into access, held off while busy
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= acc_phase;
      pslverr_q <= acc_phase & ~rd_hit;
      if (acc_phase && !i_pwrite)
      begin
        prdata_q <= rd_mux;
      end
      else
      begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // Busy mirror so the output is a flop of its own
  reg busy_q;
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= issue | (busy & (state_q != S_EXEC2) &
                ~((state_q == S_EXEC1) & ~is_call & ~skip_taken));
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_pc = pc_q;
  assign o_flush = flush_q;
  assign o_busy = busy_q;

endmodule // btcx_exec_unit

// >>> verification/btcx_exec_properties.sv
// Checker for the bit-test and call execution unit, bound to its top.
// Assumes the one clock domain and the register map of btcx_defs.vh.
`timescale 1ns/1ps
`include "btcx_defs.vh"
module btcx_exec_properties
(
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [9:0] o_pc,
  input wire o_flush,
  input wire o_busy
);
  // Completed write to the instruction register starts an operation
  wire issue = i_psel & i_penable & i_pwrite & o_pready &
    (i_paddr == `BTCX_OFF_INSTR);
  wire [2:0] op = i_pwdata[2:0]; // Opcode field of that write
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error flag without ready");
  a_rdata_quiet: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside ready cycle");
  a_ready_answer: assert property
    (i_psel && i_penable && !o_pready && !o_busy |=> o_pready)
    else $error("idle access not answered next cycle");
  a_and_one_cycle: assert property (issue && op == `BTCX_OPC_AND_IMM |=>
    o_busy ##1 (!o_busy && o_pc == $past(o_pc, 2) + 10'h1))
    else $error("and operation timing or count wrong");
  a_set_two_steps: assert property (issue && op == `BTCX_OPC_SET_BIT |=>
    o_busy [*2] ##1 !o_busy)
    else $error("set bit operation length wrong");
  a_skip_flush: assert property (issue && (op == `BTCX_OPC_SKIP_CLR ||
    op == `BTCX_OPC_SKIP_SET) |=> o_busy [*2] ##1 (o_flush == o_busy))
    else $error("skip length and discard disagree");
  a_flush_ends: assert property (o_flush |-> o_busy ##1 !o_busy)
    else $error("discard pulse not in last cycle");
  a_call_two_cycle: assert property (issue && (op == `BTCX_OPC_CALL_DIR ||
    op == `BTCX_OPC_CALL_ACC) |=> o_busy [*2] ##1 !o_busy)
    else $error("call length wrong");
  a_call_target: assert property (issue && op == `BTCX_OPC_CALL_DIR |=>
    ##2 o_pc[7:0] == $past(i_pwdata[23:16], 3))
    else $error("direct call low target wrong");
  a_pc_hold_idle: assert property (!o_busy && !i_psel |=> $stable(o_pc))
    else $error("counter moved while idle");
endmodule // btcx_exec_properties
bind btcx_exec_unit btcx_exec_properties u_props (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_pc(o_pc), .o_flush(o_flush), .o_busy(o_busy));

// >>> verification/tb_bit_test_call_exec_unit.sv
// Self-checking bench for the execution unit, driven over APB.
// Assumes the register map and opcodes of btcx_defs.vh.
`timescale 1ns/1ps
`include "btcx_defs.vh"
module tb_bit_test_call_exec_unit;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  wire [31:0] prd;
  wire rdy, err, flush, busy;
  wire [9:0] pc;
  logic [31:0] rdat; // Data of the last transfer
  logic rerr; // Error flag of the last transfer
  int n_errors = 0;
  int n_checks = 0;
  int n_flush = 0; // Discard pulses seen so far
  btcx_exec_unit dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .o_pc(pc), .o_flush(flush), .o_busy(busy));
  // Free-running 200 MHz clock
  initial
  begin
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // Count one-cycle discard pulses
  always @(posedge i_core_clk)
    if (flush === 1'b1) n_flush++;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One APB transfer; idle edge first so no signal is set twice at once
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge i_core_clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge i_core_clk);
      k++;
    end
    while (rdy !== 1'b1 && k < 40);
    rdat = prd;
    rerr = err;
    chk("pready", 32'h1, {31'h0, rdy});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task issue(input logic [2:0] op, input logic [2:0] b, input logic [5:0] fa,
    input logic [7:0] imm);
    xfer(1'b1, `BTCX_OFF_INSTR, {8'h00, imm, 2'h0, fa, 1'b0, b, 1'b0, op});
  endtask
  // Reset values and an unmapped address
  task t_reset;
    rc(`BTCX_OFF_ACC, 32'h0, "acc");
    rc(`BTCX_OFF_PC, 32'h0, "pc");
    rc(`BTCX_OFF_STATUS, 32'h0, "status");
    chk("busy", 32'h0, {31'h0, busy});
    xfer(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    $display("test reset done");
  endtask
  // AND with nonzero then zero result
  task t_and;
    xfer(1'b1, `BTCX_OFF_ACC, 32'h5A);
    issue(`BTCX_OPC_AND_IMM, 3'h0, 6'h00, 8'hAF);
    rc(`BTCX_OFF_ACC, 32'h0A, "acc");
    rc(`BTCX_OFF_STATUS, 32'h0, "zero");
    rc(`BTCX_OFF_PC, 32'h1, "pc");
    issue(`BTCX_OPC_AND_IMM, 3'h0, 6'h00, 8'hF0);
    rc(`BTCX_OFF_ACC, 32'h0, "acc");
    rc(`BTCX_OFF_STATUS, 32'h1, "zero");
    rc(`BTCX_OFF_CYCLES, 32'h2, "cycles");
    $display("test and done");
  endtask
  // Every bit of the top file register, one by one
  task t_setbit;
    xfer(1'b1, `BTCX_OFF_FILE_ADDR, 32'h3F);
    xfer(1'b1, `BTCX_OFF_FILE_DATA, 32'h0);
    for (int b = 0; b < 8; b++)
    begin
      issue(`BTCX_OPC_SET_BIT, b[2:0], 6'h3F, 8'h00);
      rc(`BTCX_OFF_FILE_DATA, (32'h2 << b) - 32'h1, "file");
    end
    rc(`BTCX_OFF_STATUS, 32'h1, "flags");
    $display("test set bit done");
  endtask
  // Both skips on a clear and on a set bit
  task t_skip;
    logic tk;
    logic [2:0] opc;
    int f;
    xfer(1'b1, `BTCX_OFF_FILE_ADDR, 32'h05);
    xfer(1'b1, `BTCX_OFF_FILE_DATA, 32'h5A);
    for (int i = 0; i < 4; i++)
    begin
      opc = (i < 2) ? `BTCX_OPC_SKIP_CLR : `BTCX_OPC_SKIP_SET;
      tk = (i == 0 || i == 2);
      xfer(1'b1, `BTCX_OFF_PC, 32'h100);
      f = n_flush;
      issue(opc, (i == 0 || i == 3) ? 3'h2 : 3'h3, 6'h05, 8'h00);
      rc(`BTCX_OFF_PC, tk ? 32'h102 : 32'h101, "pc");
      chk("flush", {31'h0, tk}, n_flush - f);
    end
    rc(`BTCX_OFF_STATUS, 32'h1, "flags");
    rc(`BTCX_OFF_CYCLES, 32'h10, "cycles");
    $display("test skip done");
  endtask
  // Direct call then accumulator call, stack grows by two
  task t_call;
    xfer(1'b1, `BTCX_OFF_PC, 32'h0A0);
    xfer(1'b1, `BTCX_OFF_PC_HIGH, 32'h2);
    issue(`BTCX_OPC_CALL_DIR, 3'h0, 6'h00, 8'h55);
    rc(`BTCX_OFF_PC, 32'h255, "pc");
    chk("pc port", 32'h255, {22'h0, pc});
    rc(`BTCX_OFF_STACK_TOP, 32'h0A1, "stack");
    rc(`BTCX_OFF_STATUS, 32'h11, "status");
    xfer(1'b1, `BTCX_OFF_ACC, 32'h34);
    xfer(1'b1, `BTCX_OFF_TABLE_HIGH, 32'h1);
    issue(`BTCX_OPC_CALL_ACC, 3'h0, 6'h00, 8'h00);
    rc(`BTCX_OFF_PC, 32'h134, "pc");
    chk("pc port", 32'h134, {22'h0, pc});
    rc(`BTCX_OFF_STACK_TOP, 32'h256, "stack");
    rc(`BTCX_OFF_STATUS, 32'h21, "status");
    rc(`BTCX_OFF_CYCLES, 32'h14, "cycles");
    $display("test call done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #50000;
    n_errors++;
    final_report;
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_and;
    t_setbit;
    t_skip;
    t_call;
    final_report;
  end
endmodule // tb_bit_test_call_exec_unit
